// ===== design/pwt_pkg.sv
// Purpose: Shared constants and carriers for the pseudowire setting decoder.
// Assumes: 100 MHz system clock, settings arrive as one octet per beat.
// Notes: Setting codes are the one-octet type values inside their container.
`default_nettype none

package pwt_pkg;
   // Clock and time base
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_PERIOD_NS = 1000000;
   localparam int MS_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [9:0] MS_PER_SEC = 10'd1000;
   // Container codes
   localparam logic [7:0] T_PW = 8'h09;
   localparam logic [7:0] T_TBL = 8'h0A;
   localparam logic [7:0] T_PW_MAP = 8'h10;
   // Per-pseudowire settings
   localparam logic [7:0] T_PW_INDEX = 8'h01;
   localparam logic [7:0] T_PW_TDM_TYPE = 8'h0B;
   localparam logic [7:0] T_PW_TBL_IDX = 8'h0C;
   localparam logic [7:0] T_PW_CES_IDX = 8'h0D;
   localparam logic [7:0] T_PW_SSRC = 8'h0E;
   localparam logic [7:0] T_PW_PEER_SSRC = 8'h0F;
   localparam logic [7:0] T_MAP_PORT = 8'h01;
   localparam logic [7:0] T_MAP_SLOTS = 8'h02;
   // Shared table settings
   localparam logic [7:0] T_TBL_IDX = 8'h01;
   localparam logic [7:0] T_TBL_PAYLOAD = 8'h02;
   localparam logic [7:0] T_TBL_RTP = 8'h03;
   localparam logic [7:0] T_TBL_JITTER = 8'h05;
   localparam logic [7:0] T_TBL_SUPPRESS = 8'h06;
   localparam logic [7:0] T_TBL_LOSS_OF_PACKET_SYNC_EXIT = 8'h07;
   localparam logic [7:0] T_TBL_LOSS_OF_PACKET_SYNC_ENTRY = 8'h08;
   localparam logic [7:0] T_TBL_REPLACE = 8'h0A;
   localparam logic [7:0] T_TBL_WINDOW = 8'h0B;
   localparam logic [7:0] T_TBL_EXCESS = 8'h0C;
   localparam logic [7:0] T_TBL_SEVERE = 8'h0F;
   localparam logic [7:0] T_TBL_TS_MODE = 8'h10;
   localparam logic [7:0] T_TBL_FILL = 8'h11;
   // Encoded values
   localparam logic [7:0] TDM_DS1 = 8'h02;
   localparam logic [7:0] TDM_E1 = 8'h03;
   localparam logic [7:0] TDM_T1_BYTE = 8'h06;
   localparam logic [7:0] TDM_NX64 = 8'h07;
   localparam logic [7:0] TDM_CAS_LO = 8'h08;
   localparam logic [7:0] TDM_CAS_HI = 8'h0A;
   localparam logic [7:0] BOOL_TRUE = 8'h01;
   localparam logic [7:0] REPL_FILLER = 8'h00;
   localparam logic [7:0] REPL_AIS = 8'h01;
   localparam logic [7:0] AIS_BYTE = 8'hFF;
   localparam logic [15:0] PAYLOAD_T1 = 16'h00C0;
   localparam logic [15:0] PAYLOAD_E1 = 16'h0100;
   // Reset values
   localparam logic [7:0] RST_TDM_TYPE = 8'h01;
   localparam logic [7:0] RST_PORT = 8'h01;
   localparam logic [7:0] RST_SUPPRESS = 8'h02;
   localparam logic [7:0] RST_TS_MODE = 8'h01;
   localparam logic [7:0] RST_FILL = 8'h00;
   localparam logic [15:0] RST_WINDOW = 16'h03E8;

   typedef struct packed {
      logic [7:0] tdm_type;
      logic cas_en;
      logic [15:0] tbl_idx;
      logic [15:0] ces_idx;
      logic [31:0] ssrc;
      logic [31:0] peer_ssrc;
      logic [7:0] port;
      logic [31:0] slot_map;
   } pwt_pw_cfg_t;

   typedef struct packed {
      logic [15:0] payload;
      logic payload_set;
      logic rtp_en;
      logic [15:0] jitter_ms;
      logic suppress;
      logic [15:0] loss_of_packet_sync_exit;
      logic [15:0] loss_of_packet_sync_entry;
      logic [7:0] replace;
      logic [15:0] window_ms;
      logic [7:0] excess_pct;
      logic [7:0] severe_pct;
      logic [7:0] ts_mode;
      logic [7:0] fill;
   } pwt_tbl_cfg_t;
endpackage : pwt_pkg

`default_nettype wire

// ===== design/pwt_tlv_policy.sv
// How it works
// - Settings are type, length, value, back to back
// - Unknown setting types are skipped silently
// - TDM type selects mode; codes 8-10 enable signaling
// - Pseudowire picks its shared table entry
// - Pseudowire holds its per-mode table index
// - Own source value inserted when headers used
// - Nonzero peer source value gates incoming frames when headers used
// - Circuit map holds port and timeslot sub-settings
// - Port number 1-255, defaults to one
// - Timeslot bitmap, 32 bits E1, 24 T1
// - Table entries selected by index, freely shared
// - Payload size defaults by line and timeslots
// - Header enable true one, false two
// - Jitter buffer depth in milliseconds
// - Suppression omits payload while failure bit set
// - Leave sync loss by run or clean window
// - Enter sync loss by late run or threshold
// - Lost packet replaced by filler, alarm or other
// - Loss rate computed over millisecond window
// - Count seconds reaching excessive loss threshold
// - Count seconds reaching severe loss threshold
// - Timestamp mode absolute, differential, prime, other
// - Fill byte played when filler selected
//
// Purpose: Decode pseudowire settings and run the playout loss policy.
// Assumes: Setting source and jitter buffer share clk_i.
// Notes: One pseudowire (PW_ID) and TBL_ENTRIES shared entries are held.
`default_nettype none

// Octet FIFO between the setting source and the decoder
module pwt_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_ff;
   logic [AW-1:0] rd_ptr_ff;
   logic [AW:0] count_ff;
   logic push;
   logic pop;

   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem[rd_ptr_ff];

   // Storage has no reset; only pointers, fill level and flags carry state
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr_ff] <= in_data_i;
      end
   end

   // Pointers, fill level and registered flags
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
         in_ready_o <= 1'b0;
         out_valid_o <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
         end
         case ({push, pop})
            2'b10: begin
               count_ff <= count_ff + 1'b1;
               in_ready_o <= (count_ff + 1'b1) != (AW+1)'(DEPTH);
               out_valid_o <= 1'b1;
            end
            2'b01: begin
               count_ff <= count_ff - 1'b1;
               in_ready_o <= 1'b1;
               out_valid_o <= count_ff != (AW+1)'(1);
            end
            default: begin
               in_ready_o <= count_ff != (AW+1)'(DEPTH);
               out_valid_o <= count_ff != '0;
            end
         endcase
      end
   end
endmodule : pwt_fifo

module pwt_tlv_policy
   import pwt_pkg::*;
#(
   parameter int MS_DIV = MS_CYCLES,
   parameter logic [15:0] PW_ID = 16'h0001,
   parameter int TBL_ENTRIES = 4,
   parameter logic [7:0] OTHER_BYTE = 8'h7F,
   parameter logic [7:0] FRAMES_PER_PKT = 8'h08
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Setting octet stream
   input wire logic cfg_valid_i,
   input wire logic [7:0] cfg_byte_i,
   output logic cfg_ready_o,
   // Decoded configuration
   output pwt_pw_cfg_t pw_cfg_o,
   output pwt_tbl_cfg_t tbl_cfg_o,
   output logic [15:0] payload_size_o,
   // Transmit header and payload control
   output logic tx_ssrc_en_o,
   output logic [31:0] tx_ssrc_o,
   input wire logic tx_fail_i,
   output logic tx_suppress_o,
   // Receive source check
   input wire logic rx_hdr_valid_i,
   input wire logic [31:0] rx_ssrc_i,
   output logic rx_drop_o,
   // Playout side
   input wire logic play_tick_i,
   input wire logic play_have_i,
   input wire logic [7:0] play_byte_i,
   input wire logic [15:0] jb_seq_ready_i,
   output logic tdm_valid_o,
   output logic [7:0] tdm_byte_o,
   output logic loss_of_packet_sync_o,
   output logic [15:0] err_sec_o,
   output logic [15:0] sev_sec_o
);
   localparam int IW = $clog2(TBL_ENTRIES);

   typedef enum logic [1:0] {ST_TYPE, ST_LEN, ST_VAL} pwt_state_t;

   // Defined length of each known setting, zero when not interpreted
   function automatic logic [7:0] pwt_exp_len(input logic [1:0] lvl, input logic [7:0] ctx,
                                              input logic [7:0] typ);
      logic [7:0] n;
      n = 8'h00;
      if (lvl == 2'd2) begin
         if (typ == T_MAP_PORT) n = 8'h01;
         if (typ == T_MAP_SLOTS) n = 8'h04;
      end else if (lvl == 2'd1 && ctx == T_PW) begin
         case (typ)
            T_PW_INDEX, T_PW_TBL_IDX, T_PW_CES_IDX: n = 8'h02;
            T_PW_TDM_TYPE: n = 8'h01;
            T_PW_SSRC, T_PW_PEER_SSRC: n = 8'h04;
            default: n = 8'h00;
         endcase
      end else if (lvl == 2'd1 && ctx == T_TBL) begin
         case (typ)
            T_TBL_IDX, T_TBL_PAYLOAD, T_TBL_JITTER, T_TBL_LOSS_OF_PACKET_SYNC_EXIT,
            T_TBL_LOSS_OF_PACKET_SYNC_ENTRY, T_TBL_WINDOW: n = 8'h02;
            T_TBL_RTP, T_TBL_SUPPRESS, T_TBL_REPLACE, T_TBL_EXCESS,
            T_TBL_SEVERE, T_TBL_TS_MODE, T_TBL_FILL: n = 8'h01;
            default: n = 8'h00;
         endcase
      end
      return n;
   endfunction : pwt_exp_len

   // Loss over a nonzero count reaches pct when lost*100 >= pct*total
   function automatic logic pwt_reached(input logic [15:0] lost, input logic [15:0] total,
                                        input logic [7:0] pct);
      return (total != 16'h0000) && (24'(lost) * 24'd100 >= 24'(pct) * 24'(total));
   endfunction : pwt_reached

   logic byte_valid;
   logic [7:0] byte_data;
   logic byte_take;

   pwt_fifo #(.WIDTH(8), .DEPTH(16)) u_fifo (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .in_valid_i(cfg_valid_i),
      .in_data_i(cfg_byte_i),
      .in_ready_o(cfg_ready_o),
      .out_valid_o(byte_valid),
      .out_data_o(byte_data),
      .out_ready_i(1'b1)
   );
   assign byte_take = byte_valid;

   // Setting decoder
   pwt_state_t state_ff;
   logic [1:0] lvl_ff;
   logic [7:0] ctx_ff;
   logic [7:0] rem1_ff;
   logic [7:0] rem2_ff;
   logic [7:0] typ_ff;
   logic [7:0] len_ff;
   logic [7:0] cnt_ff;
   logic [23:0] acc_ff;
   logic [31:0] value;
   logic [7:0] nxt_rem1;
   logic [7:0] nxt_rem2;
   logic is_box;
   logic apply;
   logic [15:0] cur_pw_ff;
   logic [IW-1:0] cur_ent_ff;

   assign value = {acc_ff, byte_data};
   assign nxt_rem1 = (lvl_ff != 2'd0) ? rem1_ff - 8'h01 : rem1_ff;
   assign nxt_rem2 = (lvl_ff == 2'd2) ? rem2_ff - 8'h01 : rem2_ff;
   assign is_box = (lvl_ff == 2'd0 && (typ_ff == T_PW || typ_ff == T_TBL))
                   || (lvl_ff == 2'd1 && ctx_ff == T_PW && typ_ff == T_PW_MAP);
   // Last value octet of a setting of the right length
   assign apply = byte_take && state_ff == ST_VAL && cnt_ff == 8'h01
                  && len_ff == pwt_exp_len(lvl_ff, ctx_ff, typ_ff);

   // Walk type, length and value octets, nesting into containers
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_ff <= ST_TYPE;
         lvl_ff <= 2'd0;
         ctx_ff <= 8'h00;
         rem1_ff <= 8'h00;
         rem2_ff <= 8'h00;
         typ_ff <= 8'h00;
         len_ff <= 8'h00;
         cnt_ff <= 8'h00;
         acc_ff <= 24'h00_0000;
      end else if (byte_take) begin
         rem1_ff <= nxt_rem1;
         rem2_ff <= nxt_rem2;
         case (state_ff)
            ST_TYPE: begin
               typ_ff <= byte_data;
               state_ff <= ST_LEN;
            end
            ST_LEN: begin
               len_ff <= byte_data;
               cnt_ff <= byte_data;
               acc_ff <= 24'h00_0000;
               state_ff <= (is_box || byte_data == 8'h00) ? ST_TYPE : ST_VAL;
               if (is_box && byte_data != 8'h00) begin
                  lvl_ff <= lvl_ff + 2'd1;
                  if (lvl_ff == 2'd0) begin
                     ctx_ff <= typ_ff;
                     rem1_ff <= byte_data;
                  end else begin
                     rem2_ff <= byte_data;
                  end
               end
            end
            ST_VAL: begin
               acc_ff <= value[23:0];
               cnt_ff <= cnt_ff - 8'h01;
               if (cnt_ff == 8'h01) begin
                  state_ff <= ST_TYPE;
               end
            end
            default: state_ff <= ST_TYPE;
         endcase
         // Close containers whose octets are used up
         if (!(state_ff == ST_LEN && is_box && byte_data != 8'h00)) begin
            if (lvl_ff == 2'd2 && nxt_rem2 == 8'h00) begin
               lvl_ff <= (nxt_rem1 == 8'h00) ? 2'd0 : 2'd1;
            end else if (lvl_ff == 2'd1 && nxt_rem1 == 8'h00) begin
               lvl_ff <= 2'd0;
            end
         end
      end
   end

   // Per-pseudowire settings
   pwt_pw_cfg_t pw_ff;
   logic pw_sel;
   assign pw_sel = cur_pw_ff == PW_ID;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cur_pw_ff <= 16'h0000;
         pw_ff <= '{tdm_type: RST_TDM_TYPE, port: RST_PORT, default: '0};
      end else if (apply && lvl_ff == 2'd1 && ctx_ff == T_PW) begin
         case (typ_ff)
            T_PW_INDEX: cur_pw_ff <= value[15:0];
            T_PW_TDM_TYPE: if (pw_sel) begin
               pw_ff.tdm_type <= value[7:0];
               pw_ff.cas_en <= value[7:0] >= TDM_CAS_LO && value[7:0] <= TDM_CAS_HI;
            end
            T_PW_TBL_IDX: if (pw_sel) pw_ff.tbl_idx <= value[15:0];
            T_PW_CES_IDX: if (pw_sel) pw_ff.ces_idx <= value[15:0];
            T_PW_SSRC: if (pw_sel) pw_ff.ssrc <= value;
            T_PW_PEER_SSRC: if (pw_sel) pw_ff.peer_ssrc <= value;
            default: ;
         endcase
      end else if (apply && lvl_ff == 2'd2 && pw_sel) begin
         if (typ_ff == T_MAP_PORT && value[7:0] != 8'h00) begin
            pw_ff.port <= value[7:0];
         end
         if (typ_ff == T_MAP_SLOTS) begin
            pw_ff.slot_map <= value;
         end
      end
   end

   // Shared table entries
   pwt_tbl_cfg_t tbl_ff [TBL_ENTRIES];
   pwt_tbl_cfg_t act;
   assign act = tbl_ff[pw_ff.tbl_idx[IW-1:0]];

   // Entries are written by index and read by any pseudowire
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cur_ent_ff <= '0;
         for (int i = 0; i < TBL_ENTRIES; i++) begin
            tbl_ff[i] <= '{suppress: 1'b0, ts_mode: RST_TS_MODE, fill: RST_FILL,
                           window_ms: RST_WINDOW, replace: REPL_FILLER, default: '0};
         end
      end else if (apply && lvl_ff == 2'd1 && ctx_ff == T_TBL) begin
         case (typ_ff)
            T_TBL_IDX: cur_ent_ff <= value[IW-1:0];
            T_TBL_PAYLOAD: begin
               tbl_ff[cur_ent_ff].payload <= value[15:0];
               tbl_ff[cur_ent_ff].payload_set <= 1'b1;
            end
            T_TBL_RTP: tbl_ff[cur_ent_ff].rtp_en <= value[7:0] == BOOL_TRUE;
            T_TBL_JITTER: tbl_ff[cur_ent_ff].jitter_ms <= value[15:0];
            T_TBL_SUPPRESS: tbl_ff[cur_ent_ff].suppress <= value[7:0] == BOOL_TRUE;
            T_TBL_LOSS_OF_PACKET_SYNC_EXIT: tbl_ff[cur_ent_ff].loss_of_packet_sync_exit <= value[15:0];
            T_TBL_LOSS_OF_PACKET_SYNC_ENTRY: tbl_ff[cur_ent_ff].loss_of_packet_sync_entry <= value[15:0];
            T_TBL_REPLACE: tbl_ff[cur_ent_ff].replace <= value[7:0];
            T_TBL_WINDOW: tbl_ff[cur_ent_ff].window_ms <= value[15:0];
            T_TBL_EXCESS: tbl_ff[cur_ent_ff].excess_pct <= value[7:0];
            T_TBL_SEVERE: tbl_ff[cur_ent_ff].severe_pct <= value[7:0];
            T_TBL_TS_MODE: tbl_ff[cur_ent_ff].ts_mode <= value[7:0];
            T_TBL_FILL: tbl_ff[cur_ent_ff].fill <= value[7:0];
            default: ;
         endcase
      end
   end

   // Payload size: explicit, else by line type or timeslot count
   logic [15:0] dflt_payload;
   always_comb begin
      dflt_payload = 16'h0000;
      for (int i = 0; i < 32; i++) begin
         dflt_payload = dflt_payload + {15'h0000, pw_ff.slot_map[i]};
      end
      dflt_payload = 16'(dflt_payload * FRAMES_PER_PKT);
      if (pw_ff.tdm_type == TDM_E1) dflt_payload = PAYLOAD_E1;
      if (pw_ff.tdm_type == TDM_DS1 || pw_ff.tdm_type == TDM_T1_BYTE) begin
         dflt_payload = PAYLOAD_T1;
      end
   end

   // Registered copies of active config and header fields
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pw_cfg_o <= '0;
         tbl_cfg_o <= '0;
         payload_size_o <= 16'h0000;
         tx_ssrc_en_o <= 1'b0;
         tx_ssrc_o <= 32'h0000_0000;
         tx_suppress_o <= 1'b0;
         rx_drop_o <= 1'b0;
      end else begin
         pw_cfg_o <= pw_ff;
         tbl_cfg_o <= act;
         payload_size_o <= act.payload_set ? act.payload : dflt_payload;
         tx_ssrc_en_o <= act.rtp_en;
         tx_ssrc_o <= pw_ff.ssrc;
         tx_suppress_o <= act.suppress && tx_fail_i;
         rx_drop_o <= rx_hdr_valid_i && act.rtp_en && pw_ff.peer_ssrc != 32'h0000_0000
                      && rx_ssrc_i != pw_ff.peer_ssrc;
      end
   end

   // Time base
   logic [$clog2(MS_DIV)-1:0] div_ff;
   logic ms_tick_ff;
   logic [9:0] ms_in_sec_ff;
   logic sec_end;
   assign sec_end = ms_tick_ff && ms_in_sec_ff == MS_PER_SEC - 10'd1;

   // Millisecond enable from the system clock, then seconds
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         div_ff <= '0;
         ms_tick_ff <= 1'b0;
         ms_in_sec_ff <= 10'd0;
      end else begin
         ms_tick_ff <= div_ff == ($clog2(MS_DIV))'(MS_DIV - 1);
         div_ff <= (div_ff == ($clog2(MS_DIV))'(MS_DIV - 1)) ? '0 : div_ff + 1'b1;
         if (ms_tick_ff) begin
            ms_in_sec_ff <= sec_end ? 10'd0 : ms_in_sec_ff + 10'd1;
         end
      end
   end

   // Loss statistics
   logic [15:0] win_ms_ff;
   logic [15:0] win_tot_ff;
   logic [15:0] win_lost_ff;
   logic [15:0] sec_tot_ff;
   logic [15:0] sec_lost_ff;
   logic win_end;
   logic win_excess;
   logic win_clean_ff;
   logic lost;
   assign lost = play_tick_i && !play_have_i;
   assign win_end = ms_tick_ff && win_ms_ff + 16'h0001 >= act.window_ms;
   assign win_excess = pwt_reached(win_lost_ff, win_tot_ff, act.excess_pct);

   // Window and per-second packet counts
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         win_ms_ff <= 16'h0000;
         win_tot_ff <= 16'h0000;
         win_lost_ff <= 16'h0000;
         win_clean_ff <= 1'b0;
         sec_tot_ff <= 16'h0000;
         sec_lost_ff <= 16'h0000;
         err_sec_o <= 16'h0000;
         sev_sec_o <= 16'h0000;
      end else begin
         win_clean_ff <= 1'b0;
         if (win_end) begin
            win_clean_ff <= !win_excess;
            win_ms_ff <= 16'h0000;
            win_tot_ff <= {15'h0000, play_tick_i};
            win_lost_ff <= {15'h0000, lost};
         end else begin
            if (ms_tick_ff) win_ms_ff <= win_ms_ff + 16'h0001;
            if (play_tick_i) win_tot_ff <= win_tot_ff + 16'h0001;
            if (lost) win_lost_ff <= win_lost_ff + 16'h0001;
         end
         if (sec_end) begin
            sec_tot_ff <= {15'h0000, play_tick_i};
            sec_lost_ff <= {15'h0000, lost};
            if (pwt_reached(sec_lost_ff, sec_tot_ff, act.excess_pct)) begin
               err_sec_o <= err_sec_o + 16'h0001;
            end
            if (pwt_reached(sec_lost_ff, sec_tot_ff, act.severe_pct)) begin
               sev_sec_o <= sev_sec_o + 16'h0001;
            end
         end else begin
            if (play_tick_i) sec_tot_ff <= sec_tot_ff + 16'h0001;
            if (lost) sec_lost_ff <= sec_lost_ff + 16'h0001;
         end
      end
   end

   // Loss of packet sync
   logic [15:0] miss_run_ff;

   // Entry by late run or threshold, exit by ready run or clean window
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         miss_run_ff <= 16'h0000;
         loss_of_packet_sync_o <= 1'b0;
      end else begin
         if (play_tick_i) begin
            miss_run_ff <= play_have_i ? 16'h0000 : miss_run_ff + 16'h0001;
         end
         if (!loss_of_packet_sync_o) begin
            if (act.loss_of_packet_sync_entry != 16'h0000) begin
               loss_of_packet_sync_o <= lost && miss_run_ff + 16'h0001 >= act.loss_of_packet_sync_entry;
            end else begin
               loss_of_packet_sync_o <= win_end && win_excess;
            end
         end else if (act.loss_of_packet_sync_exit != 16'h0000) begin
            loss_of_packet_sync_o <= jb_seq_ready_i < act.loss_of_packet_sync_exit;
         end else begin
            loss_of_packet_sync_o <= !win_clean_ff;
         end
      end
   end

   // Sync loss plays the alarm pattern; replace policy covers isolated losses
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tdm_valid_o <= 1'b0;
         tdm_byte_o <= 8'h00;
      end else begin
         tdm_valid_o <= play_tick_i;
         if (play_tick_i) begin
            if (loss_of_packet_sync_o) begin
               tdm_byte_o <= AIS_BYTE;
            end else if (play_have_i) begin
               tdm_byte_o <= play_byte_i;
            end else if (act.replace == REPL_FILLER) begin
               tdm_byte_o <= act.fill;
            end else if (act.replace == REPL_AIS) begin
               tdm_byte_o <= AIS_BYTE;
            end else begin
               tdm_byte_o <= OTHER_BYTE;
            end
         end
      end
   end
endmodule : pwt_tlv_policy

`default_nettype wire

// ===== tb/pwt_cfg_src.sv
// Purpose: Setting file source model. Assumes: shared clock.
// Notes: The bench fills q with whole settings.
`default_nettype none
module pwt_cfg_src (
   input wire logic clk_i,
   input wire logic ready_i,
   output logic valid_o,
   output logic [7:0] byte_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] q[$];
   initial valid_o = 1'b0;
   initial byte_o = 8'h00;
   // Octets go back to back and stand until taken; idle line shows a changed value
   always @(posedge clk_i) begin
      if (!(valid_o && !ready_i)) begin
         valid_o <= (q.size() > 0);
         byte_o <= (q.size() > 0) ? q.pop_front() : ~byte_o;
      end
   end
endmodule : pwt_cfg_src
`default_nettype wire

// ===== tb/pwt_chk_assertions.sv
// Purpose: Port checks. Assumes: one clock. Notes: sees top ports only.
`default_nettype none
module pwt_chk import pwt_pkg::*; (
   input wire logic clk_i, reset_n_i, rx_hdr_valid_i, rx_drop_o, play_tick_i, tdm_valid_o,
   input wire logic tx_fail_i, tx_suppress_o, play_have_i, loss_of_packet_sync_o,
   input wire logic [7:0] play_byte_i, tdm_byte_o,
   input wire logic [15:0] err_sec_o,
   input wire pwt_pw_cfg_t pw_cfg_o,
   input wire pwt_tbl_cfg_t tbl_cfg_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   a_drop_cause: assert property (rx_drop_o |-> $past(rx_hdr_valid_i)) else $error("bad drop");
   a_tick_answer: assert property (tdm_valid_o == $past(play_tick_i)) else $error("bad tdm");
   a_supp_cause: assert property (tx_suppress_o |-> $past(tx_fail_i)) else $error("bad supp");
   a_cas_codes: assert property (pw_cfg_o.cas_en == (pw_cfg_o.tdm_type inside
      {[TDM_CAS_LO:TDM_CAS_HI]})) else $error("bad cas");
   a_loss_of_packet_sync_ais: assert property (tdm_valid_o && loss_of_packet_sync_o && $past(loss_of_packet_sync_o)
      |-> tdm_byte_o == AIS_BYTE) else $error("bad ais");
   a_play_byte: assert property (tdm_valid_o && $past(play_have_i && !loss_of_packet_sync_o)
      && !loss_of_packet_sync_o |-> tdm_byte_o == $past(play_byte_i)) else $error("bad byte");
   a_fill_byte: assert property (tdm_valid_o && !loss_of_packet_sync_o && $past(!play_have_i &&
      !loss_of_packet_sync_o && tbl_cfg_o.replace == REPL_FILLER) |-> tdm_byte_o ==
      $past(tbl_cfg_o.fill)) else $error("bad fill");
   a_err_step: assert property (err_sec_o != $past(err_sec_o) |-> err_sec_o ==
      $past(err_sec_o) + 16'h0001) else $error("bad count");
   c_loss_of_packet_sync: cover property (loss_of_packet_sync_o);
   c_drop: cover property (rx_drop_o);
   c_supp: cover property (tx_suppress_o);
endmodule : pwt_chk
bind pwt_tlv_policy pwt_chk u_chk (.*);
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: Self-checking bench. Assumes: MS_DIV 10. Notes: models the loss run.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import pwt_pkg::*;
   logic clk_i = 1'b0, reset_n_i = 1'b0, tick = 1'b0, have = 1'b0, fail = 1'b0, hdr = 1'b0;
   logic [7:0] pb = 8'h00, tb_b, cb;
   logic [15:0] jb = 16'h0000, psz, es, ss;
   logic [31:0] rs = 32'h0000_0000, seed = 32'h0000_e667, ssrc, so;
   logic cv, cr, tv, loss_of_packet_sync, drop, supp, sen;
   int err_total = 0, n_compared = 0, cyc = 0, run = 0;
   pwt_pw_cfg_t pw;
   pwt_tbl_cfg_t tc;
   pwt_tlv_policy #(.MS_DIV(10)) uut (.clk_i, .reset_n_i, .cfg_valid_i(cv),
      .cfg_byte_i(cb), .cfg_ready_o(cr), .pw_cfg_o(pw), .tbl_cfg_o(tc), .payload_size_o(psz),
      .tx_ssrc_en_o(sen), .tx_ssrc_o(so), .tx_fail_i(fail), .tx_suppress_o(supp),
      .rx_hdr_valid_i(hdr), .rx_ssrc_i(rs), .rx_drop_o(drop), .play_tick_i(tick),
      .play_have_i(have), .play_byte_i(pb), .jb_seq_ready_i(jb), .tdm_valid_o(tv),
      .tdm_byte_o(tb_b), .loss_of_packet_sync_o(loss_of_packet_sync), .err_sec_o(es), .sev_sec_o(ss));
   pwt_cfg_src src (.clk_i, .ready_i(cr), .valid_o(cv), .byte_o(cb));
   // Clock and hang guard
   initial forever #5 clk_i = ~clk_i;
   always @(posedge clk_i) if (++cyc == 30000) begin
      err_total++;
      end_of_test();
   end
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // Queue settings, wait for drain and decode
   task send(input logic [7:0] b[$]);
      @(negedge clk_i);
      foreach (b[i]) src.q.push_back(b[i]);
      for (int k = 0; k < 99 && (src.q.size() > 0 || cv); k++) @(posedge clk_i);
      repeat (6) @(posedge clk_i);
   endtask : send
   task play(input logic h, input logic [7:0] exp);
      @(posedge clk_i);
      tick <= 1'b1;
      have <= h;
      pb <= 8'(rnd());
      @(posedge clk_i);
      tick <= 1'b0;
      @(negedge clk_i);
      check(tb_b, h ? pb : exp);
   endtask : play
   task end_of_test();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (6) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      check(pw.port, RST_PORT);
      check(pw.peer_ssrc, 0);
      check(tc.fill, RST_FILL);
      check(tc.ts_mode, RST_TS_MODE);
      check(tc.suppress, 0);
      ssrc = rnd();
      send('{T_PW, 8'd33, T_PW_INDEX, 8'h02, 8'h00, 8'h01, 8'h77, 8'h01, 8'h55, T_PW_TBL_IDX,
         8'h01, 8'h03, T_PW_SSRC, 8'h04, ssrc[31:24], ssrc[23:16], ssrc[15:8], ssrc[7:0],
         T_PW_PEER_SSRC, 8'h04, 8'hA5, 8'h00, 8'h00, 8'h01, T_PW_MAP, 8'h09, T_MAP_PORT, 8'h01,
         8'h05, T_MAP_SLOTS, 8'h04, 8'h00, 8'h00, 8'h06, 8'h05});
      check(pw.ssrc, ssrc);
      check(so, ssrc);
      check(pw.peer_ssrc, 32'hA500_0001);
      check(pw.port, 8'h05);
      check(pw.slot_map, 32'h0000_0605);
      check(pw.tbl_idx, 0);
      for (int c = 1; c <= 10; c++) begin
         send('{T_PW, 8'h07, T_PW_INDEX, 8'h02, 8'h00, 8'h01, T_PW_TDM_TYPE, 8'h01, 8'(c)});
         check(pw.cas_en, c >= 8);
         check(psz, c == 3 ? 256 : (c == 2 || c == 6) ? 192 : 32);
      end
      $display("test settings finished");
      send('{T_TBL, 8'd30, T_TBL_IDX, 8'h02, 8'h00, 8'h00, T_TBL_FILL, 8'h01, 8'h3C, T_TBL_RTP,
         8'h01, BOOL_TRUE, T_TBL_SUPPRESS, 8'h01, 8'h01, T_TBL_LOSS_OF_PACKET_SYNC_ENTRY, 8'h02, 8'h00, 8'h02,
         T_TBL_LOSS_OF_PACKET_SYNC_EXIT, 8'h02, 8'h00, 8'h03, T_TBL_REPLACE, 8'h01, REPL_FILLER, T_TBL_EXCESS,
         8'h01, 8'h4B, T_TBL_SEVERE, 8'h01, 8'h4D});
      fail <= 1'b1;
      hdr <= 1'b1;
      rs <= 32'hA500_0002;
      @(posedge clk_i);
      hdr <= 1'b0;
      fail <= 1'b0;
      @(negedge clk_i);
      check(supp, 1);
      check(drop, 1);
      check(sen, 1);
      for (int k = 0; k < 4; k++) begin
         play(k == 0, run >= 2 ? AIS_BYTE : 8'h3C);
         run = (k == 0) ? 0 : run + 1;
      end
      check(loss_of_packet_sync, 1);
      @(posedge clk_i);
      jb <= 16'h0003;
      for (int k = 0; k < 9 && loss_of_packet_sync; k++) @(posedge clk_i);
      @(negedge clk_i);
      check(loss_of_packet_sync, 0);
      repeat (10100) @(posedge clk_i);
      check(es, 1);
      check(ss, 0);
      $display("test playout finished");
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
